/* rfm_pkg.sv */
// Purpose : shared constants for the rail fault and good-tree mask bank
// Assumes : byte-wide registers reached over the serial management bus
// Notes   : after-reset values stand in for factory-programmed defaults
package rfm_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFF_FAULT_MASK_A = 8'ha2;
  localparam logic [7:0] OFF_FAULT_MASK_B = 8'ha3;
  localparam logic [7:0] OFF_GOOD_MASK_A  = 8'ha4;
  localparam logic [7:0] OFF_GOOD_MASK_B  = 8'ha5;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [7:0] RST_FAULT_MASK_A = 8'h00;
  localparam logic [6:0] RST_FAULT_MASK_B = 7'h20;
  localparam logic [7:0] RST_GOOD_MASK_A  = 8'h00;
  localparam logic [7:0] RST_GOOD_MASK_B  = 8'h00;
  localparam logic [6:0] RST_DEV_ADDR     = 7'h5e;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int FAULT_B_RAILS   = 5;
  localparam int GOOD_B_RAILS    = 4;
  localparam int CTL_POS         = 4;
  localparam int RSVD_ONE_POS    = 5;
  localparam int RSVD_ZERO_POS   = 6;
  localparam int SYNC_W          = 31;
  localparam logic [30:0] SYNC_RST = 31'h0000_0003;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    RFM_IDLE, RFM_ADDR, RFM_ADDR_ACK, RFM_PTR, RFM_PTR_ACK,
    RFM_WDATA, RFM_RDATA, RFM_HOST_ACK
  } rfm_state_e;

endpackage : rfm_pkg

/* rfm_sync.sv */
// Purpose : three-stage input synchroniser with agreement filter
// Assumes : inputs are asynchronous to clk
// Notes   : output changes only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module rfm_sync #(
  parameter int          W       = 1,
  parameter logic [30:0] RST_VAL = 31'h0000_0000
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_reg      <= RST_VAL[i];
          s2_reg      <= RST_VAL[i];
          s3_reg      <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            sync_out[i] <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule : rfm_sync
`default_nettype wire

/* rfm_mask_bank.sv */
// Purpose : fault shutdown masks and output-1 good-tree masks, serial bus slave
// Assumes : open-drain data pin, host clocks the bus, pins are asynchronous
// Notes   : one clock domain; bus pins pass the three-stage synchroniser
// Notes on behaviour
// - fault mask A bits 7..0 (ldo a2, switch a1, converters 6..1) at 1 keep that fault from shutdown.
// - fault mask B bits 4..0 (ldo a1, termination, switch b2, b1, ldo a3) at 1 block shutdown.
// - a good-tree mask bit at 0 includes that rail's good signal, at 1 ignores it.
// - good mask A bits 7..0 select ldo a2, switch a1 and converters 6..1.
// - good mask B bits 7..4 select control inputs 5,4,2,1, bits 3..0 rails.
// - a control-input mask bit at 0 includes that pin's state, at 1 ignores it.
`timescale 1ns/100ps
`default_nettype none
module rfm_mask_bank #(
  parameter logic [6:0] DEV_ADDR = rfm_pkg::RST_DEV_ADDR  // arbitrary bus address
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic [7:0] rail_fault_a,
  input  wire logic [4:0] rail_fault_b,
  input  wire logic [7:0] rail_good_a,
  input  wire logic [3:0] rail_good_b,
  input  wire logic [3:0] control_in,
  output var  logic       shutdown_req,
  output var  logic       good_output_pin_1
);

  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic [30:0] sync_q;
  logic        scl_s;
  logic        sda_s;
  logic [7:0]  fault_a_s;
  logic [4:0]  fault_b_s;
  logic [7:0]  good_a_s;
  logic [3:0]  good_b_s;
  logic [3:0]  ctl_s;

  rfm_sync #(
    .W       (rfm_pkg::SYNC_W),
    .RST_VAL (rfm_pkg::SYNC_RST)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({control_in, rail_good_b, rail_good_a, rail_fault_b, rail_fault_a,
                sda_in, scl_in}),
    .sync_out (sync_q)
  );

  assign scl_s     = sync_q[0];
  assign sda_s     = sync_q[1];
  assign fault_a_s = sync_q[9:2];
  assign fault_b_s = sync_q[14:10];
  assign good_a_s  = sync_q[22:15];
  assign good_b_s  = sync_q[26:23];
  assign ctl_s     = sync_q[30:27];

  // ************************************************************
  // bus condition detection
  // ************************************************************
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] fault_mask_a_reg;
  logic [6:0] fault_mask_b_reg;
  logic [7:0] good_mask_a_reg;
  logic [7:0] good_mask_b_reg;
  logic [7:0] ptr_reg;
  logic [7:0] shift_reg;
  logic       wr_en;
  logic       hit_fa;
  logic       hit_fb;
  logic       hit_ga;
  logic       hit_gb;
  logic [7:0] rd_data;

  assign hit_fa = (ptr_reg == rfm_pkg::OFF_FAULT_MASK_A);
  assign hit_fb = (ptr_reg == rfm_pkg::OFF_FAULT_MASK_B);
  assign hit_ga = (ptr_reg == rfm_pkg::OFF_GOOD_MASK_A);
  assign hit_gb = (ptr_reg == rfm_pkg::OFF_GOOD_MASK_B);
  // unmapped offsets read as zero; top bit of fault mask b is read-only zero
  assign rd_data = hit_fa ? fault_mask_a_reg :
                   hit_fb ? {1'b0, fault_mask_b_reg} :
                   hit_ga ? good_mask_a_reg :
                   hit_gb ? good_mask_b_reg : 8'h00;

  // reserved bits 6 and 5 are stored as written; keeping them at 0 and 1 is up to the host
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_mask_a_reg <= rfm_pkg::RST_FAULT_MASK_A;
      fault_mask_b_reg <= rfm_pkg::RST_FAULT_MASK_B;
      good_mask_a_reg  <= rfm_pkg::RST_GOOD_MASK_A;
      good_mask_b_reg  <= rfm_pkg::RST_GOOD_MASK_B;
    end else if (wr_en) begin
      if (hit_fa) fault_mask_a_reg <= shift_reg;
      if (hit_fb) fault_mask_b_reg <= shift_reg[6:0];
      if (hit_ga) good_mask_a_reg  <= shift_reg;
      if (hit_gb) good_mask_b_reg  <= shift_reg;
    end
  end

  // ************************************************************
  // serial slave state machine
  // ************************************************************
  rfm_pkg::rfm_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] tx_reg;
  logic       rw_reg;
  logic       addr_match;
  logic       byte_done;

  assign addr_match = (shift_reg[7:1] == DEV_ADDR);
  assign byte_done  = scl_fall & (bit_cnt_reg == rfm_pkg::BITS_PER_BYTE);
  assign wr_en      = (state_reg == rfm_pkg::RFM_WDATA) & byte_done;
  assign sda_out    = 1'b0;

  always_ff @(posedge clk) begin
    if (sys_rst || stop_cond) begin
      state_reg   <= rfm_pkg::RFM_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      rw_reg      <= 1'b0;
      sda_oe      <= 1'b0;
      if (sys_rst) ptr_reg <= 8'h00;
    end else if (start_cond) begin
      state_reg   <= rfm_pkg::RFM_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end else begin
      case (state_reg)
        rfm_pkg::RFM_ADDR, rfm_pkg::RFM_PTR, rfm_pkg::RFM_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b1;
            if (state_reg == rfm_pkg::RFM_ADDR) begin
              rw_reg    <= shift_reg[0];
              sda_oe    <= addr_match;
              state_reg <= addr_match ? rfm_pkg::RFM_ADDR_ACK : rfm_pkg::RFM_IDLE;
            end else begin
              if (state_reg == rfm_pkg::RFM_PTR) ptr_reg <= shift_reg;
              else ptr_reg <= ptr_reg + 8'h01;
              state_reg <= rfm_pkg::RFM_PTR_ACK;
            end
          end
        end
        rfm_pkg::RFM_ADDR_ACK, rfm_pkg::RFM_HOST_ACK: begin
          if (scl_rise && state_reg == rfm_pkg::RFM_HOST_ACK && sda_s) begin
            state_reg <= rfm_pkg::RFM_IDLE;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg    <= rd_data;
              sda_oe    <= ~rd_data[7];
              state_reg <= rfm_pkg::RFM_RDATA;
            end else begin
              sda_oe    <= 1'b0;
              state_reg <= rfm_pkg::RFM_PTR;
            end
          end
        end
        rfm_pkg::RFM_PTR_ACK: begin
          if (scl_fall) begin
            sda_oe    <= 1'b0;
            state_reg <= rfm_pkg::RFM_WDATA;
          end
        end
        rfm_pkg::RFM_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            sda_oe    <= 1'b0;
            ptr_reg   <= ptr_reg + 8'h01;
            state_reg <= rfm_pkg::RFM_HOST_ACK;
          end else if (scl_fall) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe <= ~tx_reg[6];
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // fault gating and good tree
  // ************************************************************
  logic [7:0] fault_live_a;
  logic [4:0] fault_live_b;
  logic [7:0] good_ok_a;
  logic [3:0] good_ok_b;
  logic [3:0] ctl_ok;
  logic       shutdown_next;
  logic       good_next;

  assign fault_live_a  = fault_a_s & ~fault_mask_a_reg;
  assign fault_live_b  = fault_b_s & ~fault_mask_b_reg[4:0];
  assign shutdown_next = |{fault_live_a, fault_live_b};
  assign good_ok_a     = good_a_s | good_mask_a_reg;
  assign good_ok_b     = good_b_s | good_mask_b_reg[3:0];
  assign ctl_ok        = ctl_s | good_mask_b_reg[7:rfm_pkg::CTL_POS];
  // all-masked leaves every term at one, so the pin reads good
  assign good_next     = &{good_ok_a, good_ok_b, ctl_ok};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shutdown_req      <= 1'b0;
      good_output_pin_1 <= 1'b0;
    end else begin
      shutdown_req      <= shutdown_next;
      good_output_pin_1 <= good_next;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_fault_a_shuts;
    @(posedge clk) disable iff (sys_rst)
      ((fault_a_s & ~fault_mask_a_reg) != 8'h00) |=> shutdown_req;
  endproperty
  a_fault_a_shuts: assert property (p_fault_a_shuts) else $error("fault a lost");

  property p_fault_b_shuts;
    @(posedge clk) disable iff (sys_rst)
      ((fault_b_s & ~fault_mask_b_reg[4:0]) != 5'h00) |=> shutdown_req;
  endproperty
  a_fault_b_shuts: assert property (p_fault_b_shuts) else $error("fault b lost");

  property p_fault_masked;
    @(posedge clk) disable iff (sys_rst)
      ((fault_a_s & ~fault_mask_a_reg) == 8'h00 &&
       (fault_b_s & ~fault_mask_b_reg[4:0]) == 5'h00) |=> !shutdown_req;
  endproperty
  a_fault_masked: assert property (p_fault_masked) else $error("masked fault shut");

  property p_good_a_drop;
    @(posedge clk) disable iff (sys_rst)
      ((~good_a_s & ~good_mask_a_reg) != 8'h00) |=> !good_output_pin_1;
  endproperty
  a_good_a_drop: assert property (p_good_a_drop) else $error("rail a not in tree");

  property p_good_b_drop;
    @(posedge clk) disable iff (sys_rst)
      ((~good_b_s & ~good_mask_b_reg[3:0]) != 4'h0) |=> !good_output_pin_1;
  endproperty
  a_good_b_drop: assert property (p_good_b_drop) else $error("rail b not in tree");

  property p_ctl_drop;
    @(posedge clk) disable iff (sys_rst)
      ((~ctl_s & ~good_mask_b_reg[7:4]) != 4'h0) |=> !good_output_pin_1;
  endproperty
  a_ctl_drop: assert property (p_ctl_drop) else $error("control not in tree");

  property p_tree_good;
    @(posedge clk) disable iff (sys_rst)
      ((good_a_s | good_mask_a_reg) == 8'hff && (good_b_s | good_mask_b_reg[3:0]) == 4'hf &&
       (ctl_s | good_mask_b_reg[7:4]) == 4'hf) |=> good_output_pin_1;
  endproperty
  a_tree_good: assert property (p_tree_good) else $error("good tree not good");

  sequence s_write_fa;
    wr_en && hit_fa;
  endsequence
  property p_write_fa;
    @(posedge clk) disable iff (sys_rst)
      s_write_fa |=> (fault_mask_a_reg == $past(shift_reg)) ##1 (shutdown_req ==
        $past(|{fault_a_s & ~fault_mask_a_reg, fault_b_s & ~fault_mask_b_reg[4:0]}));
  endproperty
  a_write_fa: assert property (p_write_fa) else $error("mask a write lost");

endmodule : rfm_mask_bank
`default_nettype wire

/* rfm_host_model.sv */
// Purpose : behavioural bus host that reaches the mask bank registers
// Assumes : no clock stretching; the data line has a pull-up
// Notes   : every bus phase lasts 10 clk, above the device sampling need
`timescale 1ns/100ps
`default_nettype none
module rfm_host_model #(
  parameter logic [6:0] DEV = rfm_pkg::RST_DEV_ADDR
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ************************************************************
  // bus phases
  // ************************************************************
  task automatic half();
    repeat (10) @(negedge clk);
  endtask : half

  // also serves as repeated start: data rises while the clock is low
  task automatic start();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop

  task automatic xfer_bit(input logic b, output logic got);
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    got = sda_line;
    scl = 1'b0;
    half();
  endtask : xfer_bit

  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], got);
      rx[i] = got;
    end
    xfer_bit(ack_in, got);
    ack = ~got;
  endtask : xfer_byte

  // ************************************************************
  // register access
  // ************************************************************
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic [7:0] wd;
    logic       a0;
    logic       a1;
    logic       a2;
    wd = data;
    if (ptr == rfm_pkg::OFF_FAULT_MASK_B) begin
      wd[6] = 1'b0;
      wd[5] = 1'b1;
    end
    start();
    xfer_byte({dev, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ptr, 1'b1, rx, a1);
    xfer_byte(wd, 1'b1, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_reg

  // single byte read, ended by a not-acknowledge
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start();
    xfer_byte({DEV, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ptr, 1'b1, rx, a1);
    start();
    xfer_byte({DEV, 1'b1}, 1'b1, rx, a2);
    xfer_byte(8'hff, 1'b1, data, a3);
    stop();
    // the device must have let go of the line for the host not-acknowledge
    ok = a0 & a1 & a2 & ~a3;
  endtask : read_reg

  // two data bytes in one frame: the pointer steps after the first
  task automatic write_pair(input logic [7:0] ptr, input logic [7:0] d0,
                            input logic [7:0] d1, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start();
    xfer_byte({DEV, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ptr, 1'b1, rx, a1);
    xfer_byte(d0, 1'b1, rx, a2);
    xfer_byte(d1, 1'b1, rx, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask : write_pair

  // host acknowledges the first byte, so the device sends the next offset
  task automatic read_pair(input logic [7:0] ptr, output logic [7:0] d0,
                           output logic [7:0] d1, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    logic       a4;
    start();
    xfer_byte({DEV, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ptr, 1'b1, rx, a1);
    start();
    xfer_byte({DEV, 1'b1}, 1'b1, rx, a2);
    xfer_byte(8'hff, 1'b0, d0, a3);
    xfer_byte(8'hff, 1'b1, d1, a4);
    stop();
    ok = a0 & a1 & a2 & ~a4;
  endtask : read_pair
endmodule : rfm_host_model
`default_nettype wire

/* test_rail_fault_and_pg_tree_masks.sv */
// Purpose : self-checking bench for the fault and good-tree mask bank
// Assumes : host model drives the bus; bench drives rail and control pins
// Notes   : bad[] marks faulty or not-good sources; zero means all healthy
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module test_rail_fault_and_pg_tree_masks;
  logic       clk;
  logic       sys_rst;
  logic       scl;
  logic       sda_drv;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       shutdown_req;
  logic       good_output_pin_1;
  logic [7:0] bad [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  int         fail_count = 0;
  int         checked = 0;
  logic [7:0] offs [4] = '{rfm_pkg::OFF_FAULT_MASK_A, rfm_pkg::OFF_FAULT_MASK_B,
                           rfm_pkg::OFF_GOOD_MASK_A, rfm_pkg::OFF_GOOD_MASK_B};
  logic [7:0] rstv [4] = '{rfm_pkg::RST_FAULT_MASK_A, {1'b0, rfm_pkg::RST_FAULT_MASK_B},
                           rfm_pkg::RST_GOOD_MASK_A, rfm_pkg::RST_GOOD_MASK_B};
  logic [7:0] fullv [4] = '{8'hff, 8'h3f, 8'hff, 8'hff};

  // open drain: pull-up unless the host or the device pulls low
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

  rfm_mask_bank #(.DEV_ADDR(rfm_pkg::RST_DEV_ADDR)) DUT (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .scl_in           (scl),
    .sda_in           (sda_line),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .rail_fault_a     (bad[0]),
    .rail_fault_b     (bad[1][4:0]),
    .rail_good_a      (~bad[2]),
    .rail_good_b      (~bad[3][3:0]),
    .control_in       (~bad[3][7:4]),
    .shutdown_req     (shutdown_req),
    .good_output_pin_1(good_output_pin_1)
  );

  rfm_host_model host (
    .clk     (clk),
    .sda_line(sda_line),
    .scl     (scl),
    .sda_drv (sda_drv)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // drives one source vector, waits past the 5 clk path, checks the output
  task automatic apply(input int r, input logic [7:0] v, input logic exp_bad);
    @(negedge clk);
    bad[r] = v;
    repeat (8) @(negedge clk);
    if (r < 2) `CHK(shutdown_req, exp_bad)
    else `CHK(good_output_pin_1, ~exp_bad)
  endtask : apply

  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    conclude();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [7:0] rd;
    logic [7:0] mv;
    logic       ok;
    int         w;
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(shutdown_req, 1'b0)
    `CHK(good_output_pin_1, 1'b1)
    for (int r = 0; r < 4; r++) begin
      host.read_reg(offs[r], rd, ok);
      `CHK(rd, rstv[r])
      `CHK(ok, 1'b1)
    end
    // all ones: bit 7 of the second fault mask is read-only zero
    for (int r = 0; r < 4; r++) begin
      host.write_reg(rfm_pkg::RST_DEV_ADDR, offs[r], 8'hff, ok);
      `CHK(ok, 1'b1)
      host.read_reg(offs[r], rd, ok);
      `CHK(rd, fullv[r])
    end
    host.write_reg(rfm_pkg::RST_DEV_ADDR ^ 7'h01, offs[0], 8'h55, ok);
    `CHK(ok, 1'b0)
    host.read_reg(offs[0], rd, ok);
    `CHK(rd, 8'hff)
    host.write_reg(rfm_pkg::RST_DEV_ADDR, 8'ha6, 8'h55, ok);
    `CHK(ok, 1'b1)
    host.read_reg(8'ha6, rd, ok);
    `CHK(rd, 8'h00)
    // each mask bit hides its own source but not its neighbour
    for (int r = 0; r < 4; r++) begin
      w = (r == 1) ? rfm_pkg::FAULT_B_RAILS : 8;
      for (int i = 0; i < w; i++) begin
        mv = 8'h01 << i;
        host.write_reg(rfm_pkg::RST_DEV_ADDR, offs[r], mv, ok);
        `CHK(ok, 1'b1)
        apply(r, mv, 1'b0);
        apply(r, 8'h01 << ((i + 1) % w), 1'b1);
      end
      apply(r, 8'h00, 1'b0);
    end
    // two-byte frames: the pointer steps on each byte, both ways
    host.write_pair(offs[2], 8'h12, 8'h34, ok);
    `CHK(ok, 1'b1)
    host.read_pair(offs[2], rd, mv, ok);
    `CHK(rd, 8'h12)
    `CHK(mv, 8'h34)
    `CHK(ok, 1'b1)
    // every good-tree source bad but every good-tree source masked
    host.write_reg(rfm_pkg::RST_DEV_ADDR, offs[2], 8'hff, ok);
    host.write_reg(rfm_pkg::RST_DEV_ADDR, offs[3], 8'hff, ok);
    @(negedge clk);
    bad[2] = 8'hff;
    apply(3, 8'hff, 1'b0);
    conclude();
  end
endmodule : test_rail_fault_and_pg_tree_masks
`default_nettype wire
